/* File: bitstream_security_gate.sv */
// Security gate: key store, bitstream admission, test-port lock.
// Assumes link inputs are timed to the link clock and the key is
// programmed only while no bitstream is being loaded.
`timescale 1ns/1ps
`include "gate_params.svh"

module bitstream_security_gate
  import gate_pkg::*;
#(
  parameter int KEY_W     = `KEY_W,
  parameter int ENC_RATIO = `ENC_RATIO
)
(
  // System clock, power-up reset, backup-supply reset
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_backup_resetn,
  // Key programming from the test port
  input  wire logic               i_key_prog,
  input  wire logic               i_key_nv,
  input  wire logic [KEY_W-1:0]   i_key_data,
  input  wire logic               i_key_erase,
  input  wire logic               i_tamper_set,
  output logic                    o_key_ok,
  output logic                    o_key_refused,
  // Test-port instruction gate
  input  wire logic               i_tp_valid,
  input  wire logic [`INSTR_W-1:0] i_tp_instr,
  output logic                    o_tp_run,
  output logic                    o_tp_refused,
  output logic                    o_reconfig_pulse,
  output logic                    o_secure_mode,
  output logic                    o_test_mode_en,
  // Open-drain configuration status pin
  input  wire logic               i_config_status_n_i,
  output logic                    o_config_status_n_o,
  output logic                    o_config_status_n_oe,
  output logic                    o_user_mode,
  // Configuration link
  input  wire logic               i_config_clock,
  input  wire logic               i_cfg_frame,
  input  wire logic [`BYTE_W-1:0] i_cfg_data,
  output logic                    o_cram_we,
  output logic [`BYTE_W-1:0]      o_cram_data,
  output logic                    o_cfg_error
);
  localparam int SLOT_W = $clog2(ENC_RATIO);

  // Backup-supply key state
  logic [KEY_W-1:0] vol_key_r;
  logic [KEY_W-1:0] vol_key_nxt;
  vkey_state_t      vkey_st_r;
  vkey_state_t      vkey_st_nxt;
  logic [KEY_W-1:0] nv_key_r;
  logic [KEY_W-1:0] nv_key_nxt;
  logic             nv_prog_r;
  logic             nv_prog_nxt;
  logic             tamper_r;
  logic             tamper_nxt;
  logic             key_ok_r;
  logic             key_ok_nxt;
  logic             key_ref_r;
  logic             key_ref_nxt;
  // Power-up control state
  logic             secure_r;
  logic             secure_nxt;
  logic             run_r;
  logic             run_nxt;
  logic             ref_r;
  logic             ref_nxt;
  logic             recfg_r;
  logic             recfg_nxt;
  logic             acc_plain_r;
  logic             acc_enc_r;
  logic [KEY_W-1:0] key_act_r;
  logic             locked;
  // Synchronisers into the system domain
  logic             stat_q1;
  logic             stat_s;
  logic             done_q1;
  logic             done_s;
  logic             fail_q1;
  logic             fail_s;
  logic             busy_q1;
  logic             busy_s;
  // Link domain
  logic             pl_q1;
  logic             pl_s;
  logic             en_q1;
  logic             en_s;
  link_state_t      st_r;
  link_state_t      st_nxt;
  logic [SLOT_W-1:0] slot_r;
  logic [SLOT_W-1:0] slot_nxt;
  logic             slow_r;
  logic             slow_nxt;
  logic             enc_r;
  logic             enc_nxt;
  logic             comp_r;
  logic             comp_nxt;
  logic             frame_q;
  logic             done_r;
  logic             fail_r;
  logic             busy_r;
  logic [KEY_W-1:0] key_cap_r;
  logic [KEY_W-1:0] key_cap_nxt;
  logic             fstart;
  logic             hdr_enc;
  logic             hdr_comp;
  logic             start;
  logic             in_valid;

  dec_if            dbus ();

  function automatic logic instr_ok(input logic [`INSTR_W-1:0] code,
                                    input logic lck,
                                    input logic tmp,
                                    input logic user);
    if (code == `INSTR_BYPASS || code == `INSTR_SAMPLE || code == `INSTR_EXTEST
        || code == `INSTR_IDCODE || code == `INSTR_ERRSHIFT)
      instr_ok = 1'h1;
    else if (code == `INSTR_LOCK || code == `INSTR_UNLOCK)
      instr_ok = user;
    else if (code == `INSTR_TPCFG)
      instr_ok = !tmp;
    else
      instr_ok = !lck;
  endfunction

  // Key programming; refused while status pin is low or a load runs
  always_comb
  begin
    vol_key_nxt = vol_key_r;
    vkey_st_nxt = vkey_st_r;
    nv_key_nxt  = nv_key_r;
    nv_prog_nxt = nv_prog_r;
    tamper_nxt  = tamper_r | i_tamper_set;
    key_ok_nxt  = 1'h0;
    key_ref_nxt = 1'h0;
    if (i_key_erase && vkey_st_r == KEY_VALID)
      vkey_st_nxt = KEY_ERASED;
    else if (i_key_prog)
    begin
      if (!stat_s || busy_s)
        key_ref_nxt = 1'h1;
      else if (i_key_nv)
      begin
        if (nv_prog_r)
          key_ref_nxt = 1'h1;
        else
        begin
          nv_key_nxt  = i_key_data;
          nv_prog_nxt = 1'h1;
          key_ok_nxt  = 1'h1;
        end
      end
      else if (tamper_r || nv_prog_r)
        key_ref_nxt = 1'h1;
      else
      begin
        vol_key_nxt = i_key_data;
        vkey_st_nxt = KEY_VALID;
        key_ok_nxt  = 1'h1;
      end
    end
  end

  // Only the backup supply clears these, so key and fuses outlive power-up
  always_ff @(posedge i_clk or negedge i_backup_resetn)
  begin
    if (!i_backup_resetn)
    begin
      vol_key_r <= '0;
      vkey_st_r <= KEY_NONE;
      nv_key_r  <= '0;
      nv_prog_r <= 1'h0;
      tamper_r  <= 1'h0;
      key_ok_r  <= 1'h0;
      key_ref_r <= 1'h0;
    end
    else
    begin
      vol_key_r <= vol_key_nxt;
      vkey_st_r <= vkey_st_nxt;
      nv_key_r  <= nv_key_nxt;
      nv_prog_r <= nv_prog_nxt;
      tamper_r  <= tamper_nxt;
      key_ok_r  <= key_ok_nxt;
      key_ref_r <= key_ref_nxt;
    end
  end

  assign locked = secure_r && tamper_r;

  always_comb
  begin
    secure_nxt = secure_r;
    run_nxt    = 1'h0;
    ref_nxt    = 1'h0;
    recfg_nxt  = 1'h0;
    if (i_tp_valid)
    begin
      if (instr_ok(i_tp_instr, locked, tamper_r, done_s))
      begin
        run_nxt = 1'h1;
        if (i_tp_instr == `INSTR_LOCK)
          secure_nxt = 1'h1;
        else if (i_tp_instr == `INSTR_UNLOCK)
          secure_nxt = 1'h0;
        else if (i_tp_instr == `INSTR_RECONFIG)
          recfg_nxt = 1'h1;
      end
      else
        ref_nxt = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      secure_r    <= 1'h1;
      run_r       <= 1'h0;
      ref_r       <= 1'h0;
      recfg_r     <= 1'h0;
      acc_plain_r <= 1'h0;
      acc_enc_r   <= 1'h0;
      key_act_r   <= '0;
      stat_q1     <= 1'h0;
      stat_s      <= 1'h0;
      done_q1     <= 1'h0;
      done_s      <= 1'h0;
      fail_q1     <= 1'h0;
      fail_s      <= 1'h0;
      busy_q1     <= 1'h0;
      busy_s      <= 1'h0;
    end
    else
    begin
      secure_r    <= secure_nxt;
      run_r       <= run_nxt;
      ref_r       <= ref_nxt;
      recfg_r     <= recfg_nxt;
      acc_plain_r <= !tamper_r;
      acc_enc_r   <= nv_prog_r || vkey_st_r == KEY_VALID;
      key_act_r   <= nv_prog_r ? nv_key_r : vol_key_r;
      stat_q1     <= i_config_status_n_i;
      stat_s      <= stat_q1;
      done_q1     <= done_r;
      done_s      <= done_q1;
      fail_q1     <= fail_r;
      fail_s      <= fail_q1;
      busy_q1     <= busy_r;
      busy_s      <= busy_q1;
    end
  end

  // Key goes only to the decoder; no port exposes it or the array
  assign o_key_ok             = key_ok_r;
  assign o_key_refused        = key_ref_r;
  assign o_tp_run             = run_r;
  assign o_tp_refused         = ref_r;
  assign o_reconfig_pulse     = recfg_r;
  assign o_secure_mode        = locked;
  assign o_test_mode_en       = !tamper_r;
  assign o_config_status_n_o  = 1'h0;
  assign o_config_status_n_oe = fail_s;
  assign o_user_mode          = done_s;

  // Link side: header byte arrives with the first frame cycle
  assign fstart   = i_cfg_frame && !frame_q;
  assign hdr_enc  = i_cfg_data[`HDR_ENC_BIT];
  assign hdr_comp = i_cfg_data[`HDR_COMP_BIT];

  always_comb
  begin
    st_nxt      = st_r;
    slot_nxt    = slot_r;
    slow_nxt    = slow_r;
    enc_nxt     = enc_r;
    comp_nxt    = comp_r;
    key_cap_nxt = key_cap_r;
    start       = 1'h0;
    in_valid    = 1'h0;
    case (st_r)
      ST_DATA:
      begin
        if (!i_cfg_frame)
          st_nxt = ST_DONE;
        else
        begin
          in_valid = (slot_r == '0);
          // Secure or packed streams give one word per ENC_RATIO clocks
          if (slow_r && slot_r != SLOT_W'(ENC_RATIO - 1))
            slot_nxt = slot_r + SLOT_W'(1);
          else
            slot_nxt = '0;
        end
      end
      default:
      begin
        if (fstart)
        begin
          if (hdr_enc ? !en_s : !pl_s)
            st_nxt = ST_FAIL;
          else
          begin
            st_nxt      = ST_DATA;
            start       = 1'h1;
            slot_nxt    = '0;
            slow_nxt    = hdr_enc || hdr_comp;
            enc_nxt     = hdr_enc;
            comp_nxt    = hdr_comp;
            key_cap_nxt = key_act_r;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_config_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pl_q1     <= 1'h0;
      pl_s      <= 1'h0;
      en_q1     <= 1'h0;
      en_s      <= 1'h0;
      st_r      <= ST_IDLE;
      slot_r    <= '0;
      slow_r    <= 1'h0;
      enc_r     <= 1'h0;
      comp_r    <= 1'h0;
      frame_q   <= 1'h0;
      done_r    <= 1'h0;
      fail_r    <= 1'h0;
      busy_r    <= 1'h0;
      key_cap_r <= '0;
    end
    else
    begin
      pl_q1     <= acc_plain_r;
      pl_s      <= pl_q1;
      en_q1     <= acc_enc_r;
      en_s      <= en_q1;
      st_r      <= st_nxt;
      slot_r    <= slot_nxt;
      slow_r    <= slow_nxt;
      enc_r     <= enc_nxt;
      comp_r    <= comp_nxt;
      frame_q   <= i_cfg_frame;
      done_r    <= st_nxt == ST_DONE;
      fail_r    <= st_nxt == ST_FAIL;
      busy_r    <= st_nxt == ST_DATA;
      key_cap_r <= key_cap_nxt;
    end
  end

  assign dbus.key      = key_cap_r;
  assign dbus.enc      = enc_r;
  assign dbus.comp     = comp_r;
  assign dbus.start    = start;
  assign dbus.in_valid = in_valid;
  assign dbus.in_data  = i_cfg_data;

  stream_decoder u_dec (
    .i_clk    (i_config_clock),
    .i_resetn (i_resetn),
    .d        (dbus)
  );

  assign o_cram_we   = dbus.out_valid;
  assign o_cram_data = dbus.out_data;
  assign o_cfg_error = fail_r;

  a_tamper_sticky: assert property (@(posedge i_clk) disable iff (!i_backup_resetn)
    tamper_r |=> tamper_r && !o_test_mode_en)
    else $error("tamper bit cleared or test mode re-enabled");

  a_secure_refuse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_tp_valid && locked && i_tp_instr == `INSTR_USERCODE |=> o_tp_refused && !o_tp_run)
    else $error("restricted instruction ran in secure mode");

  a_lock_user: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_tp_valid && !done_s && i_tp_instr == `INSTR_UNLOCK |=> $stable(secure_r) && o_tp_refused)
    else $error("unlock acted outside user mode");

  a_unlock_user: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_tp_valid && done_s && i_tp_instr == `INSTR_UNLOCK |=> !secure_r && !o_secure_mode)
    else $error("unlock in user mode did not leave secure mode");

  a_tp_cfg_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_tp_valid && tamper_r && i_tp_instr == `INSTR_TPCFG |=> o_tp_refused)
    else $error("test-port configuration ran with tamper bit set");

  a_nv_once: assert property (@(posedge i_clk) disable iff (!i_backup_resetn)
    i_key_prog && i_key_nv && nv_prog_r && !i_key_erase |=> o_key_refused && $stable(nv_key_r))
    else $error("one-time key was reprogrammed");

  a_vol_guard: assert property (@(posedge i_clk) disable iff (!i_backup_resetn)
    i_key_prog && !i_key_nv && !i_key_erase && (tamper_r || nv_prog_r)
    |=> o_key_refused && $stable(vol_key_r))
    else $error("volatile key written outside volatile untampered mode");

  a_enc_reject: assert property (@(posedge i_config_clock) disable iff (!i_resetn)
    st_r != ST_DATA && fstart && hdr_enc && !en_s |=> st_r == ST_FAIL ##1 o_cfg_error)
    else $error("encrypted file taken without a usable key");

  a_plain_reject: assert property (@(posedge i_config_clock) disable iff (!i_resetn)
    st_r != ST_DATA && fstart && !hdr_enc && !pl_s |=> st_r == ST_FAIL)
    else $error("plain file taken with tamper bit set");

  a_fail_status: assert property (@(posedge i_clk) disable iff (!i_resetn)
    fail_s |-> o_config_status_n_oe && !o_config_status_n_o)
    else $error("status pin not pulled low on refused file");
endmodule

/* File: gate_params.svh */
// Constants of the bitstream security gate: widths, header fields,
// stream pacing and test-port instruction codes.
// Assumes inclusion by bare name from the package and design files.
`ifndef GATE_PARAMS_SVH
`define GATE_PARAMS_SVH

`define KEY_W          256
`define INSTR_W        10
`define BYTE_W         8
`define ENC_RATIO      4
`define HDR_ENC_BIT    0
`define HDR_COMP_BIT   1
`define RUN_FLAG_BIT   7
`define RUN_CNT_W      2

`define INSTR_BYPASS   10'h3FF
`define INSTR_SAMPLE   10'h005
`define INSTR_EXTEST   10'h00F
`define INSTR_IDCODE   10'h006
`define INSTR_ERRSHIFT 10'h017
`define INSTR_USERCODE 10'h007
`define INSTR_HIGHZ    10'h00B
`define INSTR_CLAMP    10'h00A
`define INSTR_RECONFIG 10'h001
`define INSTR_IOCFG    10'h00D
`define INSTR_TPCFG    10'h002
`define INSTR_LOCK     10'h1F0
`define INSTR_UNLOCK   10'h1F1

`endif

/* File: gate_pkg.sv */
// Types shared by the security gate and its stream decoder.
// Assumes gate_params.svh is on the include path.
`include "gate_params.svh"

package gate_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_DONE, ST_FAIL} link_state_t;
  typedef enum logic [1:0] {KEY_NONE, KEY_VALID, KEY_ERASED} vkey_state_t;
endpackage

/* File: dec_if.sv */
// Carrier between the link-side gate logic and the stream decoder.
// Assumes both ends run on the configuration link clock.
`timescale 1ns/1ps
`include "gate_params.svh"

interface dec_if;
  logic [`KEY_W-1:0]  key;
  logic               enc;
  logic               comp;
  logic               start;
  logic               in_valid;
  logic [`BYTE_W-1:0] in_data;
  logic               out_valid;
  logic [`BYTE_W-1:0] out_data;

  modport gate (output key, enc, comp, start, in_valid, in_data,
                input out_valid, out_data);
  modport dec  (input key, enc, comp, start, in_valid, in_data,
                output out_valid, out_data);
endinterface

/* File: stream_decoder.sv */
// Decrypt-then-decompress stage for accepted configuration bytes.
// Assumes link-clock pacing leaves room for every run expansion.
`timescale 1ns/1ps
`include "gate_params.svh"

module stream_decoder
  import gate_pkg::*;
(
  // Link clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Gate side
  dec_if.dec        d
);
  logic [4:0]         idx_r;
  logic [4:0]         idx_nxt;
  logic [`BYTE_W-1:0] last_r;
  logic [`BYTE_W-1:0] last_nxt;
  logic [`RUN_CNT_W-1:0] run_r;
  logic [`RUN_CNT_W-1:0] run_nxt;
  logic [`BYTE_W-1:0] out_r;
  logic [`BYTE_W-1:0] out_nxt;
  logic               vld_r;
  logic               vld_nxt;
  logic [`BYTE_W-1:0] plain;

  // Keystream stand-in at the cipher engine's slot
  function automatic logic [`BYTE_W-1:0] key_byte(input logic [`KEY_W-1:0] key,
                                                   input logic [4:0] idx);
    key_byte = key[{idx, 3'h0} +: `BYTE_W] ^ {3'h0, idx};
  endfunction

  always_comb
  begin
    // Decryption happens before any run expansion
    plain    = d.enc ? (d.in_data ^ key_byte(d.key, idx_r)) : d.in_data;
    idx_nxt  = idx_r;
    last_nxt = last_r;
    run_nxt  = run_r;
    out_nxt  = out_r;
    vld_nxt  = 1'h0;
    if (d.start)
    begin
      idx_nxt  = 5'h00;
      last_nxt = '0;
      run_nxt  = '0;
    end
    else if (d.in_valid)
    begin
      if (d.enc)
        idx_nxt = idx_r + 5'h01;
      vld_nxt = 1'h1;
      if (d.comp && plain[`RUN_FLAG_BIT])
      begin
        out_nxt = last_r;
        run_nxt = plain[`RUN_CNT_W-1:0];
      end
      else
      begin
        out_nxt  = plain;
        last_nxt = plain;
      end
    end
    else if (run_r != '0)
    begin
      vld_nxt = 1'h1;
      out_nxt = last_r;
      run_nxt = run_r - 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      idx_r  <= 5'h00;
      last_r <= '0;
      run_r  <= '0;
      out_r  <= '0;
      vld_r  <= 1'h0;
    end
    else
    begin
      idx_r  <= idx_nxt;
      last_r <= last_nxt;
      run_r  <= run_nxt;
      out_r  <= out_nxt;
      vld_r  <= vld_nxt;
    end
  end

  assign d.out_valid = vld_r;
  assign d.out_data  = out_r;

  a_run_expand: assert property (@(posedge i_clk) disable iff (!i_resetn)
    d.in_valid && d.comp && plain[`RUN_FLAG_BIT] && plain[1:0] == 2'h2
    |=> d.out_valid [*3])
    else $error("run token did not expand to three bytes");
endmodule

/* File: cfg_source.sv */
// Partner model: external configuration memory on the link clock.
// Assumes the bench fills pl and key before each call of send.
`timescale 1ns/1ps
`include "gate_params.svh"

module cfg_source
(
  // Link clock
  input  wire logic          i_lclk,
  // Stream towards the gate
  output logic               o_frame,
  output logic [`BYTE_W-1:0] o_data
);
  logic [`BYTE_W-1:0] pl[$];
  logic [`KEY_W-1:0]  key;

  initial
  begin
    o_frame = 1'b0;
    o_data  = 8'hA5;
  end

  // Keystream stand-in mirrors the gate's decrypt slot
  task automatic send(input logic [`BYTE_W-1:0] hdr);
    int pace;
    pace = (hdr[`HDR_ENC_BIT] || hdr[`HDR_COMP_BIT]) ? `ENC_RATIO : 1;
    @(posedge i_lclk);
    o_frame <= 1'b1;
    o_data  <= hdr;
    foreach (pl[i])
    begin
      @(posedge i_lclk);
      o_data <= hdr[`HDR_ENC_BIT] ? pl[i] ^ key[8*(i%32)+:8] ^ 8'(i%32) : pl[i];
      repeat (pace - 1) @(posedge i_lclk);
    end
    @(posedge i_lclk);
    o_frame <= 1'b0;
    // Released bus must not keep showing the last byte
    o_data  <= ~o_data;
    repeat (6) @(posedge i_lclk);
    pl = {};
  endtask
endmodule

/* File: tb_bitstream_security_gate.sv */
// Self-checking bench for the bitstream security gate.
// Assumes cfg_source drives the link; status pin has a pull-up.
`timescale 1ns/1ps
`include "gate_params.svh"

module tb_bitstream_security_gate;
  logic                clk, lclk, rstn, brstn, kprog, knv, kerase, tset, tpv;
  logic [`KEY_W-1:0]   kdata;
  logic [`INSTR_W-1:0] instr;
  logic                key_ok, key_ref, tp_run, tp_ref, rcfg, sec, tmode;
  logic                st_o, st_oe, user, we, err, frame;
  logic [7:0]          cdata, ldata;
  logic [7:0]          got[$], ex[$];
  logic [9:0]          safe[5], wide[3];
  int                  error_cnt, n_checks;
  wire                 st_pin = st_oe ? st_o : 1'b1;
  localparam logic [255:0] K1 = {8{32'h1357_9BDF}};
  localparam logic [255:0] K2 = {8{32'h2468_ACE0}};

  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial lclk = 1'b0;
  always #40 lclk = ~lclk;

  cfg_source src (.i_lclk(lclk), .o_frame(frame), .o_data(ldata));

  bitstream_security_gate dut (
    .i_clk(clk), .i_resetn(rstn), .i_backup_resetn(brstn),
    .i_key_prog(kprog), .i_key_nv(knv), .i_key_data(kdata), .i_key_erase(kerase),
    .i_tamper_set(tset), .o_key_ok(key_ok), .o_key_refused(key_ref),
    .i_tp_valid(tpv), .i_tp_instr(instr), .o_tp_run(tp_run), .o_tp_refused(tp_ref),
    .o_reconfig_pulse(rcfg), .o_secure_mode(sec), .o_test_mode_en(tmode),
    .i_config_status_n_i(st_pin), .o_config_status_n_o(st_o),
    .o_config_status_n_oe(st_oe), .o_user_mode(user), .i_config_clock(lclk),
    .i_cfg_frame(frame), .i_cfg_data(ldata), .o_cram_we(we), .o_cram_data(cdata),
    .o_cfg_error(err));

  always @(negedge lclk)
    if (we === 1'b1)
      got.push_back(cdata);

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic instr_do(input logic [9:0] c, input logic run);
    @(posedge clk);
    tpv   <= 1'b1;
    instr <= c;
    @(posedge clk);
    tpv <= 1'b0;
    #1;
    chk("tp_run", tp_run, run);
    chk("tp_refused", tp_ref, !run);
  endtask

  task automatic kp(input logic nv, input logic [255:0] k, input logic ok);
    @(posedge clk);
    kprog <= 1'b1;
    knv   <= nv;
    kdata <= k;
    @(posedge clk);
    kprog <= 1'b0;
    #1;
    chk("key_ok", key_ok, ok);
    chk("key_refused", key_ref, !ok);
  endtask

  // Refused frames must write nothing and hold the status pin low
  task automatic frame_do(input logic [7:0] hdr, input logic e);
    // Key and tamper state need two link edges to reach the header check
    repeat (3) @(posedge lclk);
    got = {};
    src.send(hdr);
    chk("cfg_error", err, e);
    chk("status_oe", st_oe, e);
    chk("status_pin", st_pin, !e);
    chk("user_mode", user, !e);
    chk("n_writes", 8'(got.size()), e ? 8'h00 : 8'(ex.size()));
    if (!e)
      foreach (ex[i])
        chk("cram_data", got[i], ex[i]);
  endtask

  task automatic power_cycle();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    #500_000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    {rstn, brstn, kprog, knv, kerase, tset, tpv} = '0;
    kdata = '0;
    instr = '0;
    safe = '{`INSTR_BYPASS, `INSTR_SAMPLE, `INSTR_EXTEST, `INSTR_IDCODE, `INSTR_ERRSHIFT};
    wide = '{`INSTR_USERCODE, `INSTR_HIGHZ, `INSTR_CLAMP};
    repeat (3) @(posedge clk);
    brstn <= 1'b1;
    rstn  <= 1'b1;
    repeat (3) @(posedge clk);
    chk("test_mode", tmode, 1'b1);
    chk("secure", sec, 1'b0);
    src.pl = '{8'h11, 8'h22, 8'h33};
    ex = src.pl;
    frame_do(8'h00, 1'b0);
    src.pl = '{8'h44};
    frame_do(8'h01, 1'b1);
    src.pl = '{8'h55};
    ex = src.pl;
    frame_do(8'h00, 1'b0);
    repeat (4) @(posedge clk);
    kp(1'b0, K1, 1'b1);
    src.key = K1;
    src.pl = '{8'h5A, 8'h82};
    ex = '{8'h5A, 8'h5A, 8'h5A, 8'h5A};
    frame_do(8'h03, 1'b0);
    @(posedge clk);
    kerase <= 1'b1;
    @(posedge clk);
    kerase <= 1'b0;
    src.pl = '{8'h66};
    frame_do(8'h01, 1'b1);
    kp(1'b0, K1, 1'b0);
    src.pl = '{8'h77};
    ex = src.pl;
    frame_do(8'h00, 1'b0);
    repeat (4) @(posedge clk);
    kp(1'b0, K1, 1'b1);
    kp(1'b1, K2, 1'b1);
    kp(1'b1, K1, 1'b0);
    @(posedge clk);
    tset <= 1'b1;
    @(posedge clk);
    tset <= 1'b0;
    repeat (2) @(posedge clk);
    chk("test_mode", tmode, 1'b0);
    kp(1'b0, K1, 1'b0);
    power_cycle();
    chk("secure", sec, 1'b1);
    chk("test_mode", tmode, 1'b0);
    instr_do(`INSTR_UNLOCK, 1'b0);
    src.key = K2;
    src.pl = '{8'h99, 8'h3C};
    ex = src.pl;
    frame_do(8'h01, 1'b0);
    foreach (safe[i])
      instr_do(safe[i], 1'b1);
    instr_do(`INSTR_USERCODE, 1'b0);
    instr_do(`INSTR_TPCFG, 1'b0);
    instr_do(`INSTR_UNLOCK, 1'b1);
    chk("secure", sec, 1'b0);
    foreach (wide[i])
      instr_do(wide[i], 1'b1);
    instr_do(`INSTR_IOCFG, 1'b1);
    instr_do(`INSTR_RECONFIG, 1'b1);
    chk("reconfig", rcfg, 1'b1);
    instr_do(`INSTR_TPCFG, 1'b0);
    instr_do(`INSTR_LOCK, 1'b1);
    chk("secure", sec, 1'b1);
    instr_do(`INSTR_HIGHZ, 1'b0);
    src.pl = '{8'h12};
    frame_do(8'h00, 1'b1);
    tally_and_finish();
  end
endmodule
